// file: hw/windowed_watchdog_timer.sv
// Purpose: windowed watchdog restarted by a key write, raising internal reset requests
// Assumes: all inputs synchronous to clk_in; slow_tick_in marks one slow clock period
// Notes: the reset request is held until the system resets this block
//
// Operation
// - Key write restarts counter from zero
// - Reset value 1AH disabled, 9AH enabled
// - Wrong key requests reset, deferred if clock stopped
// - Bit access requests reset, deferred if stopped
// - Reads return reset value, never key
// - Enable option starts counting and access detection
// - Overflow without restart requests reset
// - Three bits select two^10..two^17 periods
// - Two bits select 25..100 percent open
// - Closed-window write requests reset, except first
// - First key write restarts anywhere before overflow
// - Unconfigured fetch requests reset when enabled
// - Unconfigured data access requests reset, top exempt
// - Restart takes effect at next slow tick
// - Restart at last count prevents overflow
// - Lock option decides freeze in halt/stop
// - Slow oscillator stop holds counter uncleared
// - Counter keeps running during flash programming
// - Every watchdog reset sets cause flag
`timescale 1ns/1ps
module windowed_watchdog_timer
	import dog_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire option_type option_in,
	input wire cpu_access_type cpu_in,
	input wire area_report_type area_in,
	input wire logic slow_tick_in,
	input wire logic halt_mode_in,
	input wire logic stop_mode_in,
	input wire logic slow_osc_stop_bit_in,
	input wire logic flash_busy_in,
	output logic [7:0] read_data_out,
	output logic reset_request_out,
	output logic dog_reset_cause_flag_out,
	output logic [COUNT_WIDTH-1:0] count_out
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [SYNC_STAGES-1:0] reset_pipe;
	logic reset_n;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reset_pipe <= '0;
		end else begin
			reset_pipe <= {reset_pipe[SYNC_STAGES-2:0], 1'b1};
		end
	end
	assign reset_n = reset_pipe[SYNC_STAGES-1];

	// ----------------------------------------
	// Option capture
	// ----------------------------------------
	// Options are straps: caught by a clocked load after release, not by the reset itself
	option_type opt;
	logic opt_loaded;

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			opt <= '0;
			opt_loaded <= 1'b0;
		end else if (!opt_loaded) begin
			opt <= option_in;
			opt_loaded <= 1'b1;
		end
	end

	// ----------------------------------------
	// Window arithmetic
	// ----------------------------------------
	logic [2:0] overflow_code;
	logic [1:0] open_code;
	logic [COUNT_WIDTH:0] limit;
	logic [COUNT_WIDTH:0] quarter;
	logic [COUNT_WIDTH:0] closed_end;
	logic enabled;
	logic clock_running;
	logic count_advance;

	assign overflow_code = {opt.overflow_select_bit2, opt.overflow_select_bit1, opt.overflow_select_bit0};
	assign open_code = {opt.open_period_select_hi, opt.open_period_select_lo};
	assign limit = (COUNT_WIDTH+1)'(1) << (OVERFLOW_BASE_EXP + int'(overflow_code));
	assign quarter = limit >> 2;
	// Closed part spans the leading share of the interval not opened
	assign closed_end = limit - quarter * (COUNT_WIDTH+1)'({open_code} + 3'h1);
	assign enabled = opt_loaded && opt.dog_count_enable_opt;
	// Slow oscillator only stops when the lock option allows it
	assign clock_running = opt.slow_osc_lock_opt || !slow_osc_stop_bit_in;
	// Flash activity deliberately plays no part here
	assign count_advance = enabled && slow_tick_in && clock_running
		&& (opt.slow_osc_lock_opt || !(halt_mode_in || stop_mode_in));

	// ----------------------------------------
	// Write decoding
	// ----------------------------------------
	logic key_hit;
	logic key_good;
	logic in_closed;
	logic write_fault;
	logic area_fault;
	logic first_done;

	assign key_hit = cpu_in.write && cpu_in.addr == RESTART_KEY_ADDR;
	assign in_closed = {1'b0, count_out} < closed_end;
	assign key_good = key_hit && !cpu_in.bit_access && cpu_in.data == RESTART_KEY_VALUE
		&& (!first_done || !in_closed);
	assign write_fault = key_hit && !key_good;
	assign area_fault = enabled && (area_in.fetch_unconfigured
		|| (area_in.data_unconfigured && area_in.data_addr < EXEMPT_AREA_LOW));

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			first_done <= 1'b0;
		end else if (key_hit) begin
			first_done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Restart waits for the next slow tick, so the interval may stretch by up to one period
	logic restart_pending;
	logic overflow_now;

	assign overflow_now = count_advance && !restart_pending
		&& {1'b0, count_out} == limit - (COUNT_WIDTH+1)'(1);

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			restart_pending <= 1'b0;
		end else if (key_good && enabled) begin
			restart_pending <= 1'b1;
		end else if (count_advance) begin
			restart_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			count_out <= '0;
		end else if (count_advance) begin
			if (restart_pending) begin
				count_out <= '0;
			end else if (!overflow_now) begin
				count_out <= count_out + COUNT_WIDTH'(1);
			end
		end
	end

	// ----------------------------------------
	// Reset request
	// ----------------------------------------
	// A fault seen while the slow clock stands is parked until it runs again
	logic fault_pending;

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			fault_pending <= 1'b0;
		end else if (write_fault || area_fault || overflow_now) begin
			fault_pending <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			reset_request_out <= 1'b0;
			dog_reset_cause_flag_out <= 1'b0;
		end else if ((fault_pending || write_fault || area_fault) && clock_running) begin
			reset_request_out <= 1'b1;
			dog_reset_cause_flag_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n) begin
		if (!reset_n) begin
			read_data_out <= RESET_VALUE_DISABLED;
		end else if (cpu_in.read && cpu_in.addr == RESTART_KEY_ADDR) begin
			read_data_out <= opt.dog_count_enable_opt ? RESET_VALUE_ENABLED : RESET_VALUE_DISABLED;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n);

	sequence good_key_s;
		key_good && enabled;
	endsequence

	// A restart is armed first and applied by the next counting tick
	sequence restart_tick_s;
		restart_pending && count_advance;
	endsequence

	sequence wrap_guard_s;
		restart_tick_s ##0 {1'b0, count_out} == limit - (COUNT_WIDTH+1)'(1);
	endsequence

	sequence plain_step_s;
		count_advance && !restart_pending && !overflow_now;
	endsequence

	// ----------------------------------------
	// Counter checks
	// ----------------------------------------
	a_restart_arms: assert property (good_key_s
		|=> restart_pending)
		else $error("restart not armed");
	a_restart_clears: assert property (restart_tick_s
		|=> count_out == '0)
		else $error("restart did not clear count");
	a_late_restart: assert property (wrap_guard_s ##0 !(write_fault || area_fault || fault_pending)
		|=> !fault_pending)
		else $error("last-count restart overflowed");
	a_count_step: assert property (plain_step_s ##0 flash_busy_in
		|=> count_out == $past(count_out) + COUNT_WIDTH'(1))
		else $error("counter stalled in flash work");
	a_count_bound: assert property ({1'b0, count_out} < limit)
		else $error("count passed limit");
	a_disabled_hold: assert property (opt_loaded && !opt.dog_count_enable_opt
		|=> $stable(count_out))
		else $error("disabled counter moved");
	a_overflow_reset: assert property (overflow_now && clock_running
		|=> ##1 reset_request_out)
		else $error("overflow missed");
	a_freeze_halt: assert property (!opt.slow_osc_lock_opt && (halt_mode_in || stop_mode_in)
		|=> $stable(count_out))
		else $error("counter ran in halt");
	a_stop_keeps: assert property (!opt.slow_osc_lock_opt && slow_osc_stop_bit_in
		|=> (count_out == $past(count_out) && !reset_request_out) || $past(reset_request_out))
		else $error("stopped oscillator moved count");

	// ----------------------------------------
	// Window checks
	// ----------------------------------------
	a_window_full: assert property (open_code == 2'b11
		|-> !in_closed)
		else $error("full window had closed part");
	a_window_quarter: assert property (open_code == 2'b00 && {1'b0, count_out} < (limit >> 1)
		|-> in_closed)
		else $error("quarter window opened early");
	a_closed_write: assert property (key_hit && first_done && in_closed && clock_running
		|=> reset_request_out)
		else $error("closed-window write missed");
	a_first_write: assert property (key_hit && !first_done && !cpu_in.bit_access
		&& cpu_in.data == RESTART_KEY_VALUE && enabled
		|=> restart_pending)
		else $error("first key write ignored");

	// ----------------------------------------
	// Fault checks
	// ----------------------------------------
	a_wrong_key: assert property (key_hit && cpu_in.data != RESTART_KEY_VALUE && clock_running
		|=> reset_request_out)
		else $error("wrong key missed");
	a_bit_access: assert property (key_hit && cpu_in.bit_access && clock_running
		|=> reset_request_out)
		else $error("bit access missed");
	a_deferred_fault: assert property (fault_pending && clock_running
		|=> reset_request_out)
		else $error("parked fault not raised");
	a_fetch_fault: assert property (enabled && area_in.fetch_unconfigured
		|=> reset_request_out || !$past(clock_running))
		else $error("fetch fault missed");
	a_data_fault: assert property (enabled && area_in.data_unconfigured
		&& area_in.data_addr < EXEMPT_AREA_LOW && clock_running
		|=> reset_request_out)
		else $error("data fault missed");
	a_exempt_quiet: assert property (area_in.data_unconfigured && area_in.data_addr >= EXEMPT_AREA_LOW
		&& !area_in.fetch_unconfigured && !key_hit && !fault_pending && !reset_request_out
		|=> !reset_request_out)
		else $error("exempt access faulted");
	a_disabled_quiet: assert property (!enabled && !key_hit && !fault_pending && !reset_request_out
		|=> !reset_request_out)
		else $error("disabled detection faulted");
	a_cause_flag: assert property (reset_request_out |-> dog_reset_cause_flag_out)
		else $error("cause flag missing");
	a_sticky_request: assert property (reset_request_out
		|=> reset_request_out && dog_reset_cause_flag_out)
		else $error("request dropped");

	// ----------------------------------------
	// Read checks
	// ----------------------------------------
	a_read_value: assert property (cpu_in.read && cpu_in.addr == RESTART_KEY_ADDR
		|=> read_data_out != RESTART_KEY_VALUE)
		else $error("read returned key");
	a_read_enabled: assert property (cpu_in.read && cpu_in.addr == RESTART_KEY_ADDR
		&& opt.dog_count_enable_opt
		|=> read_data_out == RESET_VALUE_ENABLED)
		else $error("enabled read value wrong");
	a_read_disabled: assert property (cpu_in.read && cpu_in.addr == RESTART_KEY_ADDR
		&& !opt.dog_count_enable_opt
		|=> read_data_out == RESET_VALUE_DISABLED)
		else $error("disabled read value wrong");
endmodule

// file: shared/dog_pkg.sv
// Purpose: constants and carriers for the windowed watchdog
// Assumes: 25 MHz system clock, slow clock given as a one-cycle tick
// Notes: option fields are latched once after reset release
package dog_pkg;
	localparam logic [15:0] RESTART_KEY_ADDR = 16'hff99;
	localparam logic [7:0] RESTART_KEY_VALUE = 8'hac;
	localparam logic [7:0] RESET_VALUE_ENABLED = 8'h9a;
	localparam logic [7:0] RESET_VALUE_DISABLED = 8'h1a;
	localparam logic [15:0] EXEMPT_AREA_LOW = 16'hfb00;
	localparam int OVERFLOW_BASE_EXP = 10;
	localparam int COUNT_WIDTH = 17;
	localparam real CLOCK_PERIOD_NS = 40.0;

	// Option byte fields that steer the watchdog
	typedef struct packed {
		logic open_period_select_hi;
		logic open_period_select_lo;
		logic dog_count_enable_opt;
		logic overflow_select_bit2;
		logic overflow_select_bit1;
		logic overflow_select_bit0;
		logic slow_osc_lock_opt;
	} option_type;

	// One register access from the CPU core
	typedef struct packed {
		logic write;
		logic read;
		logic bit_access;
		logic [15:0] addr;
		logic [7:0] data;
	} cpu_access_type;

	// Reports from the memory-area checker
	typedef struct packed {
		logic fetch_unconfigured;
		logic data_unconfigured;
		logic [15:0] data_addr;
	} area_report_type;
endpackage

// file: dv/cpu_core_model.sv
// Purpose: CPU core and slow oscillator model on the far side of the watchdog
// Assumes: requests launched 1 ns after a rising edge, held one cycle
// Notes: released strobes drop to zero; address and data lines show the inverse of the last value
`timescale 1ns/1ps
module cpu_core_model
	import dog_pkg::*;
(
	input wire logic clk_in,
	input wire logic osc_stop_in,
	output cpu_access_type cpu_out,
	output area_report_type area_out,
	output logic slow_tick_out
);
	initial begin
		cpu_out = '0;
		area_out = '0;
		slow_tick_out = 1'b0;
	end
	// Slow clock halves the system rate and stands still when stopped
	always @(posedge clk_in) begin
		slow_tick_out <= ~slow_tick_out & ~osc_stop_in;
	end
	task automatic acc(input logic w, input logic r, input logic b, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 cpu_out = {w, r, b, a, d};
		@(posedge clk_in);
		#1 cpu_out = {3'b000, ~a, ~d};
	endtask
	task automatic flt(input logic f, input logic d, input logic [15:0] a);
		@(posedge clk_in);
		#1 area_out = {f, d, a};
		@(posedge clk_in);
		#1 area_out = {2'b00, ~a};
	endtask
endmodule

// file: dv/test_windowed_watchdog_timer.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: overflow code 000 with 50 percent window, never 000 with 25 percent
// Notes: one slow tick every two system cycles
`timescale 1ns/1ps
module test_windowed_watchdog_timer;
	import dog_pkg::*;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	option_type opt = 7'h30;
	logic osc_stop = 1'b0;
	logic halt = 1'b0;
	logic stop = 1'b0;
	logic tick, req, flag;
	cpu_access_type cpu;
	area_report_type area;
	logic [7:0] rd;
	logic [COUNT_WIDTH-1:0] cnt, held;
	int errors = 0;
	int n_tests = 0;
	initial forever #20 clk_in = ~clk_in;
	cpu_core_model cpu_m (.clk_in(clk_in), .osc_stop_in(osc_stop), .cpu_out(cpu), .area_out(area),
		.slow_tick_out(tick));
	windowed_watchdog_timer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .option_in(opt), .cpu_in(cpu),
		.area_in(area), .slow_tick_in(tick), .halt_mode_in(halt), .stop_mode_in(stop),
		.slow_osc_stop_bit_in(osc_stop), .flash_busy_in(1'b1), .read_data_out(rd),
		.reset_request_out(req), .dog_reset_cause_flag_out(flag), .count_out(cnt));
	task automatic summarize();
		$display("Checks %0d, errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rst(input option_type o);
		#1 reset_n_in = 1'b0;
		opt = o;
		repeat (20) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#1;
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	initial begin
		#(40 * 20000);
		errors++;
		summarize();
	end
	initial begin
		rst(7'h30);
		cpu_m.acc(1'b0, 1'b1, 1'b0, RESTART_KEY_ADDR, 8'h00);
		pause(1);
		chk("read", RESET_VALUE_ENABLED, rd);
		// First key lands deep in the closed part and must still restart
		for (int i = 0; i < 800 && cnt < 17'd300; i++) @(posedge clk_in);
		cpu_m.acc(1'b1, 1'b0, 1'b0, RESTART_KEY_ADDR, RESTART_KEY_VALUE);
		pause(4);
		chk("first key", 8'h00, {7'h00, req});
		chk("cleared", 8'h01, {7'h00, cnt < 17'h8});
		cpu_m.acc(1'b0, 1'b1, 1'b0, RESTART_KEY_ADDR, 8'h00);
		pause(1);
		chk("read key", RESET_VALUE_ENABLED, rd);
		for (int i = 0; i < 1200 && cnt < 17'd520; i++) @(posedge clk_in);
		cpu_m.acc(1'b1, 1'b0, 1'b0, RESTART_KEY_ADDR, RESTART_KEY_VALUE);
		pause(4);
		chk("open key", 8'h01, {6'h00, req, cnt < 17'h8});
		cpu_m.acc(1'b1, 1'b0, 1'b0, RESTART_KEY_ADDR, RESTART_KEY_VALUE);
		pause(2);
		chk("closed key", 8'h03, {6'h00, req, flag});
		rst(7'h30);
		osc_stop = 1'b1;
		pause(2);
		held = cnt;
		cpu_m.acc(1'b1, 1'b0, 1'b0, RESTART_KEY_ADDR, 8'h55);
		pause(20);
		chk("deferred", 8'h01, {6'h00, req, cnt === held});
		osc_stop = 1'b0;
		pause(4);
		chk("resumed", 8'h01, {7'h00, req});
		rst(7'h30);
		cpu_m.acc(1'b1, 1'b0, 1'b1, RESTART_KEY_ADDR, RESTART_KEY_VALUE);
		pause(2);
		chk("bit access", 8'h01, {7'h00, req});
		rst(7'h30);
		cpu_m.flt(1'b0, 1'b1, EXEMPT_AREA_LOW);
		pause(2);
		chk("exempt", 8'h00, {7'h00, req});
		cpu_m.flt(1'b0, 1'b1, 16'hfaff);
		pause(2);
		chk("data fault", 8'h01, {7'h00, req});
		rst(7'h30);
		cpu_m.flt(1'b1, 1'b0, 16'h0000);
		pause(2);
		chk("fetch fault", 8'h01, {7'h00, req});
		rst(7'h30);
		halt = 1'b1;
		held = cnt;
		pause(20);
		chk("halt hold", 8'h01, {7'h00, cnt === held});
		halt = 1'b0;
		stop = 1'b1;
		held = cnt;
		pause(20);
		chk("stop hold", 8'h01, {7'h00, cnt === held});
		stop = 1'b0;
		pause(1900);
		chk("early", 8'h00, {7'h00, req});
		for (int i = 0; i < 300 && req !== 1'b1; i++) @(posedge clk_in);
		pause(1);
		chk("overflow", 8'h03, {6'h00, req, flag});
		rst(7'h20);
		cpu_m.acc(1'b0, 1'b1, 1'b0, RESTART_KEY_ADDR, 8'h00);
		cpu_m.flt(1'b1, 1'b0, 16'h0000);
		pause(20);
		chk("off read", RESET_VALUE_DISABLED, rd);
		chk("off idle", 8'h00, {7'h00, req | (cnt != 17'h0)});
		summarize();
	end
endmodule
